/* rtl/mrt_timer.sv */
`timescale 1ns/1ns
`include "mrt_consts.svh"

// Notes on behaviour
// - Match flag sits at control bit 7
// - Flag clears by reading 1, writing 0
// - Writing 1 to flag does nothing
// - Select field picks divide 4/8/16/64
// - Counter steps on each selected tick
// - On match: clear counter, set flag, continue
// - Counter is sixteen-bit readable up-counter
// - Counter resets zero, holds in standby
// - Constant resets all ones, holds standby
// - Match acts on next count tick
// - Reserved control bits read zero
// - Control bit 6 is plain storage
// - Start bit zero halts, resets zero
// - Each match pulses a transfer request

module mrt_timer
  import mrt_pkg::*;
(
  input wire logic pclk, // Peripheral clock, 25 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic standby, // Standby: freeze counting
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic dma_req // Transfer request pulse
);

  logic count_start_r;
  logic start_spare_r;
  logic match_flag_r;
  logic csr_spare_r;
  logic [1:0] cks_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] const_r;
  mrt_clr_e clr_state_r;
  logic wr_start;
  logic wr_csr;
  logic wr_cnt;
  logic wr_const;
  logic rd_csr;
  logic tick;
  logic step;
  logic match_ev;
  logic setup;
  logic wr;
  logic rd;
  logic hit_start;
  logic hit_csr;
  logic hit_cnt;
  logic hit_const;
  logic mapped;
  logic [31:0] rdata;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  mrt_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .cks(cks_r),
    .tick(tick)
  );

  // Address decode
  always_comb
  begin
    hit_start = 1'b0;
    hit_csr = 1'b0;
    hit_cnt = 1'b0;
    hit_const = 1'b0;
    if (addr_is(paddr, `MRT_ADDR_START))
    begin
      hit_start = 1'b1;
    end
    else if (addr_is(paddr, `MRT_ADDR_CSR))
    begin
      hit_csr = 1'b1;
    end
    else if (addr_is(paddr, `MRT_ADDR_CNT))
    begin
      hit_cnt = 1'b1;
    end
    else if (addr_is(paddr, `MRT_ADDR_CONST))
    begin
      hit_const = 1'b1;
    end
  end

  assign mapped = hit_start | hit_csr | hit_cnt | hit_const;
  assign setup = psel & ~penable;
  // Access phase completes in the first penable cycle (pready high then)
  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & penable & ~pwrite & pready;

  assign step = count_start_r & tick & ~standby;
  assign match_ev = step & (cnt_r == const_r);

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (match_ev)
    begin
      cnt_nxt = 16'h0000;
    end
    else if (step)
    begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  // Read words; bits outside the defined fields stay zero
  function automatic logic [31:0] start_word(input logic run, input logic spare);
    start_word = 32'h0000_0000;
    start_word[`MRT_START_BIT] = run;
    start_word[`MRT_START_SPARE_BIT] = spare;
  endfunction

  function automatic logic [31:0] csr_word(input logic flag, input logic spare, input logic [1:0] sel);
    csr_word = 32'h0000_0000;
    csr_word[`MRT_CSR_FLAG_BIT] = flag;
    csr_word[`MRT_CSR_SPARE_BIT] = spare;
    csr_word[`MRT_CSR_CKS_HI:`MRT_CSR_CKS_LO] = sel;
  endfunction

  function automatic logic [31:0] half_word(input logic [15:0] v);
    half_word = {16'h0000, v};
  endfunction

  // Read mux
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (hit_start)
    begin
      rdata = start_word(count_start_r, start_spare_r);
    end
    else if (hit_csr)
    begin
      rdata = csr_word(match_flag_r, csr_spare_r, cks_r);
    end
    else if (hit_cnt)
    begin
      rdata = half_word(cnt_r);
    end
    else if (hit_const)
    begin
      rdata = half_word(const_r);
    end
  end

  // Per-register strobes for the access phase
  assign wr_start = wr & hit_start;
  assign wr_csr = wr & hit_csr;
  assign wr_cnt = wr & hit_cnt;
  assign wr_const = wr & hit_const;
  assign rd_csr = rd & hit_csr;

  // APB answer: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
    end
  end

  // Read data stands only while pready is high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (setup & ~pwrite)
    begin
      prdata <= rdata;
    end
    else if (pready)
    begin
      prdata <= 32'h0000_0000;
    end
  end

  // Run control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_start_r <= 1'b0;
    end
    else if (wr_start)
    begin
      count_start_r <= pwdata[`MRT_START_BIT];
    end
  end

  // Spare storage bit of the start register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_spare_r <= 1'b0;
    end
    else if (wr_start)
    begin
      start_spare_r <= pwdata[`MRT_START_SPARE_BIT];
    end
  end

  // Count clock select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cks_r <= 2'b00;
    end
    else if (wr_csr)
    begin
      cks_r <= pwdata[`MRT_CSR_CKS_HI:`MRT_CSR_CKS_LO];
    end
  end

  // Spare storage bit of the control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      csr_spare_r <= 1'b0;
    end
    else if (wr_csr)
    begin
      csr_spare_r <= pwdata[`MRT_CSR_SPARE_BIT];
    end
  end

  // Clear sequence: arms on the read data that showed the flag set,
  // so a flag set after the read was sampled can not be cleared unseen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_state_r <= MRT_CLR_IDLE;
    end
    else
    begin
      case (clr_state_r)
        MRT_CLR_IDLE:
        begin
          if (rd_csr && prdata[`MRT_CSR_FLAG_BIT])
          begin
            clr_state_r <= MRT_CLR_ARMED;
          end
        end
        MRT_CLR_ARMED:
        begin
          if (wr_csr)
          begin
            clr_state_r <= MRT_CLR_IDLE;
          end
        end
        default:
        begin
          clr_state_r <= MRT_CLR_IDLE;
        end
      endcase
    end
  end

  // Match flag: a set in the same cycle beats the software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_flag_r <= 1'b0;
    end
    else if (match_ev)
    begin
      match_flag_r <= 1'b1;
    end
    else if (wr_csr && clr_state_r == MRT_CLR_ARMED && !pwdata[`MRT_CSR_FLAG_BIT])
    begin
      match_flag_r <= 1'b0;
    end
  end

  // Counter: software write loses to a same-cycle count update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= `MRT_CNT_RST;
    end
    else if (step)
    begin
      cnt_r <= cnt_nxt;
    end
    else if (wr_cnt)
    begin
      cnt_r <= pwdata[15:0];
    end
  end

  // Constant register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      const_r <= `MRT_CONST_RST;
    end
    else if (wr_const)
    begin
      const_r <= pwdata[15:0];
    end
  end

  // Transfer request: one pulse per match, the cycle after it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_req <= 1'b0;
    end
    else
    begin
      dma_req <= match_ev;
    end
  end

endmodule // mrt_timer

/* pkg/mrt_consts.svh */
`ifndef MRT_CONSTS_SVH
`define MRT_CONSTS_SVH

// Register byte addresses
`define MRT_ADDR_START 12'h000
`define MRT_ADDR_CSR 12'h004
`define MRT_ADDR_CNT 12'h008
`define MRT_ADDR_CONST 12'h00C

// Control/status field positions
`define MRT_CSR_FLAG_BIT 7
`define MRT_CSR_SPARE_BIT 6
`define MRT_CSR_CKS_HI 1
`define MRT_CSR_CKS_LO 0
`define MRT_START_SPARE_BIT 1
`define MRT_START_BIT 0

// Reset values
`define MRT_CNT_RST 16'h0000
`define MRT_CONST_RST 16'hFFFF

// Prescaler widths and division terminal counts (count minus one)
`define MRT_PRE_W 6
`define MRT_DIV4_LAST 6'h03
`define MRT_DIV8_LAST 6'h07
`define MRT_DIV16_LAST 6'h0F
`define MRT_DIV64_LAST 6'h3F

`endif

/* pkg/mrt_pkg.sv */
package mrt_pkg;

  typedef enum logic [1:0] {
    MRT_CKS_DIV4,
    MRT_CKS_DIV8,
    MRT_CKS_DIV16,
    MRT_CKS_DIV64
  } mrt_cks_e;

  typedef enum logic [1:0] {
    MRT_CLR_IDLE,
    MRT_CLR_ARMED
  } mrt_clr_e;

endpackage

/* rtl/mrt_prescaler.sv */
`timescale 1ns/1ns
`include "mrt_consts.svh"

module mrt_prescaler
  import mrt_pkg::*;
(
  input wire logic pclk, // Peripheral clock
  input wire logic presetn, // Async reset, active low
  input wire logic [1:0] cks, // Count clock select
  output logic tick // One-cycle count enable
);

  logic [`MRT_PRE_W-1:0] pre_r;
  logic [`MRT_PRE_W-1:0] last;

  always_comb
  begin
    case (mrt_cks_e'(cks))
      MRT_CKS_DIV4: last = `MRT_DIV4_LAST;
      MRT_CKS_DIV8: last = `MRT_DIV8_LAST;
      MRT_CKS_DIV16: last = `MRT_DIV16_LAST;
      default: last = `MRT_DIV64_LAST;
    endcase
  end

  // Free-running divider; tick when low bits reach terminal count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= '0;
    else
      pre_r <= pre_r + 6'h01;
  end

  assign tick = ((pre_r & last) == last);

endmodule // mrt_prescaler

/* dv/mrt_properties.sv */
`timescale 1ns/1ns
`include "mrt_consts.svh"
module mrt_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic dma_req // Request
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_quiet;
    !dma_req [*3];
  endsequence
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("late ready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  property p_upper; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper data");
  property p_resv; pready && paddr == `MRT_ADDR_CSR |-> prdata[15:8] == 8'h00 && prdata[5:2] == 4'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits");
  property p_unmap; pready && paddr > `MRT_ADDR_CONST |-> pslverr && prdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access");
  property p_req; dma_req |=> s_quiet; endproperty
  a_req: assert property (p_req) else $error("request spacing");
endmodule // mrt_chk
bind mrt_timer mrt_chk mrt_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_req(dma_req));

/* dv/mrt_dma_model.sv */
`timescale 1ns/1ns
module mrt_dma_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic dma_req, // Request pulse
  output int req_count // Requests taken
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_count <= 0;
    else if (dma_req === 1'b1)
      req_count <= req_count + 1;
  end
endmodule // mrt_dma_model

/* dv/mrt_timer_test.sv */
`timescale 1ns/1ns
`include "mrt_consts.svh"
module mrt_timer_test;
  logic pclk = 0, presetn = 0, standby = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, dma_req, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  int req_count, err_count = 0, check_count = 0, cyc = 0, c, n;
  int div[4] = '{4, 8, 16, 64};
  always #20 pclk = ~pclk;
  mrt_timer mrt_timer_inst (.pclk(pclk), .presetn(presetn), .standby(standby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_req(dma_req));
  mrt_dma_model mrt_dma_model_inst (.pclk(pclk), .presetn(presetn), .dma_req(dma_req), .req_count(req_count));
  task automatic test_done;
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      test_done;
    end
  end
  initial
  begin
    void'($urandom(32'h415e));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("cnt", `MRT_ADDR_CNT, 32'h0000_0000);
    rdchk("const", `MRT_ADDR_CONST, 32'h0000_FFFF);
    rdchk("csr", `MRT_ADDR_CSR, 32'h0000_0000);
    rdchk("start", `MRT_ADDR_START, 32'h0000_0000);
    rdchk("unmapped", 12'h010, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, er});
    bus(1'b1, `MRT_ADDR_CSR, 32'hFFFF_FFFF);
    rdchk("csr_wr", `MRT_ADDR_CSR, 32'h0000_0043);
    for (int s = 0; s < 4; s++)
    begin
      c = $urandom % 4;
      bus(1'b1, `MRT_ADDR_CNT, 32'h0000_0000);
      bus(1'b1, `MRT_ADDR_CSR, s);
      bus(1'b1, `MRT_ADDR_CONST, c);
      bus(1'b1, `MRT_ADDR_START, 32'h0000_0001);
      while (dma_req !== 1'b1)
        @(posedge pclk);
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (dma_req !== 1'b1);
      chk("period", (c + 1) * div[s], n);
      bus(1'b1, `MRT_ADDR_START, 32'h0000_0000);
      bus(1'b1, `MRT_ADDR_CSR, s);
      rdchk("flag_kept", `MRT_ADDR_CSR, 32'h0000_0080 | s);
      bus(1'b1, `MRT_ADDR_CSR, 32'h0000_0080 | s);
      rdchk("flag_w1", `MRT_ADDR_CSR, 32'h0000_0080 | s);
      bus(1'b1, `MRT_ADDR_CSR, s);
      rdchk("flag_clr", `MRT_ADDR_CSR, s);
    end
    chk("reqs", 32'h0000_0001, {31'h0, req_count >= 8});
    c = 32'h0000_0100 + ($urandom % 32'h0000_FE00);
    bus(1'b1, `MRT_ADDR_CSR, 32'h0000_0000);
    bus(1'b1, `MRT_ADDR_CONST, c);
    bus(1'b1, `MRT_ADDR_CNT, 32'h0000_0005);
    standby <= 1'b1;
    bus(1'b1, `MRT_ADDR_START, 32'h0000_0001);
    repeat (100) @(posedge pclk);
    rdchk("cnt_hold", `MRT_ADDR_CNT, 32'h0000_0005);
    rdchk("const_hold", `MRT_ADDR_CONST, c);
    standby <= 1'b0;
    repeat (64) @(posedge pclk);
    bus(1'b0, `MRT_ADDR_CNT, 32'h0000_0000);
    chk("cnt_run", 32'h0000_0001, {31'h0, rd > 32'd5 && rd < 32'd40});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("cnt_rst", `MRT_ADDR_CNT, 32'h0000_0000);
    rdchk("const_rst", `MRT_ADDR_CONST, 32'h0000_FFFF);
    rdchk("start_rst", `MRT_ADDR_START, 32'h0000_0000);
    test_done;
  end
endmodule // mrt_timer_test
